// ===== verilog/tlic_ctrl.sv
// two-level interrupt controller with axi4-lite registers
// Function
// - global enable low blocks every request
// - each source needs its own enable bit
// - fixed vectors 0003H, 000BH, 0013H, 001BH, 0023H
// - trigger select zero means low level request
// - trigger select one latches falling edge
// - priority bit one means high level
// - block requests at or below serviced level
// - same level order: ext0, tmr0, ext1, tmr1, serial
//
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
module tlic_ctrl
    import tlic_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              clk_en,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              external_request_pin_0,
    input  wire logic              external_request_pin_1,
    input  wire logic              timer0_overflow_flag,
    input  wire logic              timer1_overflow_flag,
    input  wire logic              receive_done_flag,
    input  wire logic              transmit_done_flag,
    output logic                   timer0_flag_clear,
    output logic                   timer1_flag_clear,
    output logic                   core_irq_req,
    output logic [VEC_W-1:0]       core_irq_vector,
    output logic [SRC_W-1:0]       core_irq_src,
    output logic                   core_irq_level,
    input  wire logic              core_irq_ack,
    input  wire logic              core_irq_return,
    output logic                   irq
);
    logic              global_interrupt_enable;
    logic [NSRC-1:0]   en_r;
    logic [NSRC-1:0]   prio_r;
    logic [1:0]        trig_r;
    logic [NSRC-1:0]   evt_stat_r;
    logic [NSRC-1:0]   evt_mask_r;
    logic              svc_lo_r;
    logic              svc_hi_r;
    logic              aw_held_r;
    logic              w_held_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [DATA_W-1:0] wdata_r;
    logic              wstrb0_r;
    logic [1:0]        pin_s;
    logic [1:0]        ext_pend;
    logic [NSRC-1:0]   flags;
    logic [NSRC-1:0]   req_vec;
    logic [NSRC-1:0]   req_hi;
    logic [NSRC-1:0]   req_lo;
    logic [NSRC-1:0]   cand;
    logic              cand_any;
    logic [SRC_W-1:0]  cand_src;
    logic              ack_take;
    logic [NSRC-1:0]   ack_onehot;
    logic              wr_do;
    logic              wr_ok;
    logic [7:0]        wbyte;
    logic [DATA_W-1:0] rd_nxt;
    logic              rd_ok;

    tlic_sync #(.RST_VAL(1'b1)) u_sync0 (
        .aclk    (aclk),
        .aresetn (aresetn),
        .clk_en  (clk_en),
        .pin     (external_request_pin_0),
        .pin_s   (pin_s[0])
    );

    tlic_sync #(.RST_VAL(1'b1)) u_sync1 (
        .aclk    (aclk),
        .aresetn (aresetn),
        .clk_en  (clk_en),
        .pin     (external_request_pin_1),
        .pin_s   (pin_s[1])
    );

    tlic_ext_req u_ext0 (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .clk_en    (clk_en),
        .pin_s     (pin_s[0]),
        .trig_edge (trig_r[0]),
        .ack       (ack_onehot[SRC_EXT0]),
        .pending_r (ext_pend[0])
    );

    tlic_ext_req u_ext1 (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .clk_en    (clk_en),
        .pin_s     (pin_s[1]),
        .trig_edge (trig_r[1]),
        .ack       (ack_onehot[SRC_EXT1]),
        .pending_r (ext_pend[1])
    );

    // request selection
    always_comb begin
        flags = {receive_done_flag | transmit_done_flag, timer1_overflow_flag,
                 ext_pend[1], timer0_overflow_flag, ext_pend[0]};
        req_vec = global_interrupt_enable ? (flags & en_r) : '0;
        req_hi  = req_vec & prio_r;
        req_lo  = req_vec & ~prio_r;
        if (svc_hi_r) begin
            cand = '0;
        end else if (req_hi != '0) begin
            cand = req_hi;
        end else if (svc_lo_r) begin
            cand = '0;
        end else begin
            cand = req_lo;
        end
        cand_any = cand != '0;
        cand_src = SRC_SERIAL;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (cand[i]) begin
                cand_src = SRC_W'(i);
            end
        end
        ack_take   = core_irq_ack && core_irq_req;
        ack_onehot = ack_take ? NSRC'(1 << core_irq_src) : '0;
    end

    // request presented to the core
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_irq_req    <= 1'b0;
            core_irq_vector <= VEC_BASE;
            core_irq_src    <= SRC_EXT0;
            core_irq_level  <= 1'b0;
        end else if (clk_en) begin
            core_irq_req    <= cand_any && !ack_take;
            core_irq_src    <= cand_src;
            core_irq_vector <= VEC_BASE + (VEC_W'(cand_src) << VEC_STEP_SH);
            core_irq_level  <= (prio_r & NSRC'(1 << cand_src)) != '0;
        end
    end

    // in-service levels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            svc_lo_r <= 1'b0;
            svc_hi_r <= 1'b0;
        end else if (clk_en) begin
            if (ack_take) begin
                if (core_irq_level) begin
                    svc_hi_r <= 1'b1;
                end else begin
                    svc_lo_r <= 1'b1;
                end
            end else if (core_irq_return) begin
                if (svc_hi_r) begin
                    svc_hi_r <= 1'b0;
                end else begin
                    svc_lo_r <= 1'b0;
                end
            end
        end
    end

    // hardware clear of timer flags on vectoring
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer0_flag_clear <= 1'b0;
            timer1_flag_clear <= 1'b0;
        end else if (clk_en) begin
            timer0_flag_clear <= ack_onehot[SRC_TMR0];
            timer1_flag_clear <= ack_onehot[SRC_TMR1];
        end
    end

    // write channel capture
    always_comb begin
        wr_do = aw_held_r && w_held_r && !s_axi_bvalid;
        wbyte = wdata_r[7:0];
        unique case (awaddr_r)
            OFS_ENABLE, OFS_PRIORITY, OFS_TRIGGER,
            OFS_EVT_STAT, OFS_EVT_MASK: wr_ok = 1'b1;
            default:                    wr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r     <= 1'b0;
            w_held_r      <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            awaddr_r      <= '0;
            wdata_r       <= '0;
            wstrb0_r      <= 1'b0;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r     <= 1'b1;
                s_axi_awready <= 1'b0;
                awaddr_r      <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r     <= 1'b1;
                s_axi_wready <= 1'b0;
                wdata_r      <= s_axi_wdata;
                wstrb0_r     <= s_axi_wstrb[0];
            end
            if (wr_do) begin
                aw_held_r    <= 1'b0;
                w_held_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // control registers; reserved bits have no storage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            global_interrupt_enable <= 1'b0;
            en_r       <= RST_SRC_BITS;
            prio_r     <= RST_SRC_BITS;
            trig_r     <= RST_TRIGGER;
            evt_mask_r <= RST_SRC_BITS;
        end else if (clk_en && wr_do && wstrb0_r) begin
            unique case (awaddr_r)
                OFS_ENABLE: begin
                    global_interrupt_enable <= wbyte[BIT_GLOBAL_EN];
                    en_r <= wbyte[SRC_MSB:0];
                end
                OFS_PRIORITY: prio_r     <= wbyte[SRC_MSB:0];
                OFS_TRIGGER:  trig_r     <= wbyte[1:0];
                OFS_EVT_MASK: evt_mask_r <= wbyte[SRC_MSB:0];
                default: ;
            endcase
        end
    end

    // sticky vectoring events, write one to clear, set wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_stat_r <= RST_SRC_BITS;
            irq        <= 1'b0;
        end else if (clk_en) begin
            if (wr_do && wstrb0_r && awaddr_r == OFS_EVT_STAT) begin
                evt_stat_r <= (evt_stat_r & ~wbyte[SRC_MSB:0]) | ack_onehot;
            end else begin
                evt_stat_r <= evt_stat_r | ack_onehot;
            end
            irq <= (evt_stat_r & evt_mask_r) != '0;
        end
    end

    // read channel
    always_comb begin
        rd_nxt = '0;
        rd_ok  = 1'b1;
        unique case (s_axi_araddr)
            OFS_ENABLE: begin
                rd_nxt[BIT_GLOBAL_EN] = global_interrupt_enable;
                rd_nxt[SRC_MSB:0]     = en_r;
            end
            OFS_PRIORITY: rd_nxt[SRC_MSB:0] = prio_r;
            OFS_TRIGGER:  rd_nxt[1:0]       = trig_r;
            OFS_STATE: begin
                rd_nxt[SRC_MSB:0] = req_vec;
                rd_nxt[ST_SVC_LO] = svc_lo_r;
                rd_nxt[ST_SVC_HI] = svc_hi_r;
            end
            OFS_EVT_STAT: rd_nxt[SRC_MSB:0] = evt_stat_r;
            OFS_EVT_MASK: rd_nxt[SRC_MSB:0] = evt_mask_r;
            default:      rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_nxt;
                s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_global_off;
        clk_en && !global_interrupt_enable |=> !core_irq_req;
    endproperty
    a_global_off: assert property (p_global_off) else $error("request with global off");

    property p_src_enabled;
        core_irq_req && $past(clk_en) |-> (($past(en_r) >> core_irq_src) & 5'h01) != 5'h00;
    endproperty
    a_src_enabled: assert property (p_src_enabled) else $error("disabled source");

    property p_vector;
        core_irq_req |-> core_irq_vector == 16'h0003 + 16'(core_irq_src) * 16'h0008;
    endproperty
    a_vector: assert property (p_vector) else $error("wrong vector");

    property p_level_mode;
        clk_en && !trig_r[0] ##1 clk_en |-> ext_pend[0] == !$past(pin_s[0]);
    endproperty
    a_level_mode: assert property (p_level_mode) else $error("level request lost");

    property p_edge_mode;
        clk_en && trig_r[0] && $past(pin_s[0]) && !pin_s[0] |=> ext_pend[0];
    endproperty
    a_edge_mode: assert property (p_edge_mode) else $error("edge not latched");

    property p_level_prio;
        core_irq_req && $past(clk_en)
            |-> core_irq_level == ((($past(prio_r) >> core_irq_src) & 5'h01) != 5'h00);
    endproperty
    a_level_prio: assert property (p_level_prio) else $error("wrong level");

    property p_block_hi;
        clk_en && svc_hi_r |=> !core_irq_req;
    endproperty
    a_block_hi: assert property (p_block_hi) else $error("request under high");

    property p_block_lo;
        core_irq_req && $past(clk_en) && $past(svc_lo_r) |-> core_irq_level;
    endproperty
    a_block_lo: assert property (p_block_lo) else $error("low request under low");

    property p_order;
        core_irq_req && $past(clk_en)
            |-> ($past(cand) & ((5'h01 << core_irq_src) - 5'h01)) == 5'h00;
    endproperty
    a_order: assert property (p_order) else $error("fixed order broken");

    property p_nest;
        $rose(svc_lo_r) |-> !svc_hi_r;
    endproperty
    a_nest: assert property (p_nest) else $error("low nested under high");

    property p_reserved_read;
        s_axi_rvalid && s_axi_rresp == RESP_OKAY |-> s_axi_rdata[6:5] == 2'h0;
    endproperty
    a_reserved_read: assert property (p_reserved_read) else $error("reserved bits");

    property p_preempt;
        svc_lo_r && core_irq_req && core_irq_ack;
    endproperty
    c_preempt: cover property (p_preempt);

    property p_edge_ack;
        trig_r[0] && ack_onehot[0];
    endproperty
    c_edge_ack: cover property (p_edge_ack);

    property p_irq_out;
        !irq ##1 irq;
    endproperty
    c_irq_out: cover property (p_irq_out);

    property p_bad_addr;
        s_axi_bvalid && s_axi_bresp == RESP_SLVERR;
    endproperty
    c_bad_addr: cover property (p_bad_addr);
endmodule : tlic_ctrl
`default_nettype wire

// ===== verilog/tlic_pkg.sv
// constants shared by the two-level interrupt controller
package tlic_pkg;
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam int          NSRC          = 5;
    localparam int          SRC_W         = 3;
    localparam int          VEC_W         = 16;
    // register byte offsets
    localparam logic [7:0]  OFS_ENABLE    = 8'h00;
    localparam logic [7:0]  OFS_PRIORITY  = 8'h04;
    localparam logic [7:0]  OFS_TRIGGER   = 8'h08;
    localparam logic [7:0]  OFS_STATE     = 8'h0C;
    localparam logic [7:0]  OFS_EVT_STAT  = 8'h10;
    localparam logic [7:0]  OFS_EVT_MASK  = 8'h14;
    // enable register layout
    localparam int          BIT_GLOBAL_EN = 7;
    localparam int          SRC_MSB       = 4;
    // state register layout
    localparam int          ST_SVC_LO     = 8;
    localparam int          ST_SVC_HI     = 9;
    // reset values
    localparam logic [4:0]  RST_SRC_BITS  = 5'h00;
    localparam logic [1:0]  RST_TRIGGER   = 2'h0;
    // source indices, fixed order, highest first
    localparam logic [2:0]  SRC_EXT0      = 3'h0;
    localparam logic [2:0]  SRC_TMR0      = 3'h1;
    localparam logic [2:0]  SRC_EXT1      = 3'h2;
    localparam logic [2:0]  SRC_TMR1      = 3'h3;
    localparam logic [2:0]  SRC_SERIAL    = 3'h4;
    // vector = base + 8 * source index
    localparam logic [15:0] VEC_BASE      = 16'h0003;
    localparam int          VEC_STEP_SH   = 3;
    // bus answers
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage : tlic_pkg

// ===== verilog/tlic_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module tlic_sync
    import tlic_pkg::*;
#(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic clk_en,
    input  wire logic pin,
    output logic      pin_s
);
    logic meta_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= RST_VAL;
            pin_s  <= RST_VAL;
        end else if (clk_en) begin
            meta_r <= pin;
            pin_s  <= meta_r;
        end
    end
endmodule : tlic_sync
`default_nettype wire

// ===== verilog/tlic_ext_req.sv
// external request capture: low level or falling edge
`timescale 1ns/100ps
`default_nettype none
module tlic_ext_req
    import tlic_pkg::*;
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic clk_en,
    input  wire logic pin_s,
    input  wire logic trig_edge,
    input  wire logic ack,
    output logic      pending_r
);
    logic prev_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_r    <= 1'b1;
            pending_r <= 1'b0;
        end else if (clk_en) begin
            prev_r <= pin_s;
            if (!trig_edge) begin
                pending_r <= !pin_s;
            end else if (prev_r && !pin_s) begin
                pending_r <= 1'b1;
            end else if (ack) begin
                pending_r <= 1'b0;
            end
        end
    end
endmodule : tlic_ext_req
`default_nettype wire

// ===== verif/tlic_core_model.sv
// processor core model: takes presented requests and ends service routines
`timescale 1ns/100ps
`default_nettype none
module tlic_core_model
    import tlic_pkg::*;
(
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             auto_ack,
    input  wire logic [3:0]       ack_wait,
    input  wire logic             ret_go,
    input  wire logic             core_irq_req,
    input  wire logic [VEC_W-1:0] core_irq_vector,
    input  wire logic [SRC_W-1:0] core_irq_src,
    input  wire logic             core_irq_level,
    output logic                  core_irq_ack,
    output logic                  core_irq_return,
    output logic [VEC_W-1:0]      got_vec,
    output logic [SRC_W-1:0]      got_src,
    output logic                  got_lvl,
    output logic [7:0]            n_ack
);
    logic [3:0] wait_r;
    // ack pulse after a chosen wait; vector taken with the request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_irq_ack <= 1'b0;
            wait_r       <= 4'h0;
            n_ack        <= 8'h00;
        end else if (core_irq_ack) begin
            core_irq_ack <= 1'b0;
            wait_r       <= 4'h0;
            if (core_irq_req) begin
                got_vec <= core_irq_vector;
                got_src <= core_irq_src;
                got_lvl <= core_irq_level;
                n_ack   <= n_ack + 8'h01;
            end
        end else if (auto_ack && core_irq_req) begin
            if (wait_r == ack_wait) begin
                core_irq_ack <= 1'b1;
            end else begin
                wait_r <= wait_r + 4'h1;
            end
        end else begin
            wait_r <= 4'h0;
        end
    end
    // routine end as a one-cycle pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_irq_return <= 1'b0;
        end else begin
            core_irq_return <= ret_go;
        end
    end
endmodule : tlic_core_model
`default_nettype wire

// ===== verif/test_two_level_interrupt_control.sv
// self-checking bench for the two-level interrupt controller
`timescale 1ns/100ps
`default_nettype none
module test_two_level_interrupt_control;
    import tlic_pkg::*;
    localparam logic [15:0] VT [5] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023};
    logic              aclk, aresetn, clk_en, auto_ack, ret_go, core_irq_ack, core_irq_return;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]        s_axi_wstrb, ack_wait;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic              s_axi_rvalid, s_axi_rready, irq, core_irq_req, core_irq_level, got_lvl;
    logic              external_request_pin_0, external_request_pin_1, receive_done_flag;
    logic              timer0_overflow_flag, timer1_overflow_flag, transmit_done_flag;
    logic              timer0_flag_clear, timer1_flag_clear;
    logic [VEC_W-1:0]  core_irq_vector, got_vec;
    logic [SRC_W-1:0]  core_irq_src, got_src;
    logic [7:0]        n_ack;
    int                n_mismatch, n_tests, acks, cyc;

    tlic_ctrl dut (.aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .external_request_pin_0,
        .external_request_pin_1, .timer0_overflow_flag, .timer1_overflow_flag,
        .receive_done_flag, .transmit_done_flag, .timer0_flag_clear, .timer1_flag_clear,
        .core_irq_req, .core_irq_vector, .core_irq_src, .core_irq_level, .core_irq_ack,
        .core_irq_return, .irq);
    tlic_core_model core (.aclk, .aresetn, .auto_ack, .ack_wait, .ret_go, .core_irq_req,
        .core_irq_vector, .core_irq_src, .core_irq_level, .core_irq_ack, .core_irq_return,
        .got_vec, .got_src, .got_lvl, .n_ack);

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    // timer flags drop when the controller clears them
    always @(posedge aclk) begin
        cyc++;
        if (timer0_flag_clear) timer0_overflow_flag <= 1'b0;
        if (timer1_flag_clear) timer1_overflow_flag <= 1'b0;
        if (cyc == 20000) begin
            n_mismatch++;
            close_out();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk(32'(s_axi_bresp), 32'(er));
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : axw

    task automatic axr(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        chk(32'(s_axi_rresp), 32'(er));
        if (exp !== 32'hFFFFFFFF) chk(rd, exp);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : axr

    task automatic wait_ack(input logic [2:0] src, input logic lvl);
        int t;
        t = 0;
        while (32'(n_ack) == acks && t < 300) begin
            @(posedge aclk);
            t++;
        end
        acks++;
        chk(32'(n_ack), acks);
        chk(32'(got_src), 32'(src));
        chk(32'(got_vec), 32'(VT[src]));
        chk(32'(got_lvl), 32'(lvl));
    endtask : wait_ack

    task automatic idle_chk(input int n);
        repeat (n) @(posedge aclk);
        chk(32'(n_ack), acks);
    endtask : idle_chk

    task automatic ret(input int n);
        repeat (n) @(posedge aclk);
        ret_go <= 1'b1;
        @(posedge aclk);
        ret_go <= 1'b0;
    endtask : ret

    task automatic t_regs;
        axr(OFS_ENABLE, 32'h0, RESP_OKAY);
        axr(OFS_TRIGGER, 32'h0, RESP_OKAY);
        axw(OFS_ENABLE, 32'hFF, RESP_OKAY);
        axr(OFS_ENABLE, 32'h9F, RESP_OKAY);
        axw(OFS_PRIORITY, 32'hFF, RESP_OKAY);
        axr(OFS_PRIORITY, 32'h1F, RESP_OKAY);
        axw(8'h40, 32'h1, RESP_SLVERR);
        axr(8'h40, 32'h0, RESP_SLVERR);
        axw(OFS_PRIORITY, 32'h0, RESP_OKAY);
        axw(OFS_ENABLE, 32'h1F, RESP_OKAY);
    endtask : t_regs

    task automatic t_gate;
        timer0_overflow_flag <= 1'b1;
        idle_chk(10);
        chk(32'(core_irq_req), 32'h0);
        axw(OFS_ENABLE, 32'h88, RESP_OKAY);
        idle_chk(10);
        chk(32'(core_irq_req), 32'h0);
        axw(OFS_ENABLE, 32'h82, RESP_OKAY);
        wait_ack(SRC_TMR0, 1'b0);
        ret(6);
    endtask : t_gate

    task automatic t_order;
        ack_wait <= 4'h4;
        axw(OFS_ENABLE, 32'h9F, RESP_OKAY);
        external_request_pin_0 <= 1'b0;
        external_request_pin_1 <= 1'b0;
        timer0_overflow_flag   <= 1'b1;
        timer1_overflow_flag   <= 1'b1;
        receive_done_flag      <= 1'b1;
        for (int k = 0; k < NSRC; k++) begin
            wait_ack(3'(k), 1'b0);
            if (k == 0) external_request_pin_0 <= 1'b1;
            if (k == 2) external_request_pin_1 <= 1'b1;
            if (k == 4) receive_done_flag <= 1'b0;
            ret(6);
        end
        ack_wait <= 4'h0;
    endtask : t_order

    task automatic t_irq;
        axr(OFS_EVT_STAT, 32'h1F, RESP_OKAY);
        chk(32'(irq), 32'h0);
        axw(OFS_EVT_MASK, 32'h01, RESP_OKAY);
        chk(32'(irq), 32'h1);
        axw(OFS_EVT_STAT, 32'h01, RESP_OKAY);
        chk(32'(irq), 32'h0);
        axr(OFS_EVT_STAT, 32'h1E, RESP_OKAY);
    endtask : t_irq

    task automatic t_nest;
        axw(OFS_PRIORITY, 32'h08, RESP_OKAY);
        axw(OFS_ENABLE, 32'h8E, RESP_OKAY);
        timer0_overflow_flag <= 1'b1;
        wait_ack(SRC_TMR0, 1'b0);
        external_request_pin_1 <= 1'b0;
        idle_chk(10);
        timer1_overflow_flag <= 1'b1;
        wait_ack(SRC_TMR1, 1'b1);
        axr(OFS_STATE, 32'hFFFFFFFF, RESP_OKAY);
        chk(32'(rd[9:8]), 32'h3);
        idle_chk(10);
        ret(0);
        idle_chk(10);
        ret(0);
        wait_ack(SRC_EXT1, 1'b0);
        external_request_pin_1 <= 1'b1;
        ret(6);
    endtask : t_nest

    task automatic t_edge;
        ack_wait <= 4'h5;
        axw(OFS_PRIORITY, 32'h00, RESP_OKAY);
        axw(OFS_TRIGGER, 32'h01, RESP_OKAY);
        axw(OFS_ENABLE, 32'h81, RESP_OKAY);
        external_request_pin_0 <= 1'b0;
        repeat (3) @(posedge aclk);
        external_request_pin_0 <= 1'b1;
        wait_ack(SRC_EXT0, 1'b0);
        ret(6);
        idle_chk(12);
        axw(OFS_TRIGGER, 32'h00, RESP_OKAY);
        ack_wait <= 4'h0;
        external_request_pin_0 <= 1'b0;
        wait_ack(SRC_EXT0, 1'b0);
        ret(4);
        wait_ack(SRC_EXT0, 1'b0);
        external_request_pin_0 <= 1'b1;
        ret(6);
        idle_chk(2);
        clk_en <= 1'b0;
        external_request_pin_0 <= 1'b0;
        idle_chk(8);
        clk_en <= 1'b1;
        wait_ack(SRC_EXT0, 1'b0);
        external_request_pin_0 <= 1'b1;
        ret(6);
    endtask : t_edge

    task automatic close_out;
        $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : close_out

    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {timer0_overflow_flag, timer1_overflow_flag, receive_done_flag} = '0;
        {transmit_done_flag, ret_go, aresetn, n_mismatch, n_tests, acks, cyc} = '0;
        s_axi_wstrb = 4'hF;
        clk_en      = 1'b1;
        auto_ack    = 1'b1;
        ack_wait    = 4'h0;
        external_request_pin_0 = 1'b1;
        external_request_pin_1 = 1'b1;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_gate();
        t_order();
        t_irq();
        t_nest();
        t_edge();
        transmit_done_flag <= 1'b1;
        axw(OFS_ENABLE, 32'h90, RESP_OKAY);
        wait_ack(SRC_SERIAL, 1'b0);
        close_out();
    end
endmodule : test_two_level_interrupt_control
`default_nettype wire
